// [design/pfrp_pkg.sv]
// package for the program flash read port
// assumes one core clock, one instruction per enabled cycle
`default_nettype none
package pfrp_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned IMPL_W = 10;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned DEPTH = 1024;
  localparam logic [7:0] DATA_LOW_RST = 8'h00;
  localparam logic [5:0] DATA_HIGH_RST = 6'h00;
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic [4:0] ADDR_HIGH_RST = 5'h00;
  localparam int unsigned READ_BIT_POS = 0;
  typedef enum logic [1:0] {
    PFRP_IDLE = 2'b00,
    PFRP_WAIT = 2'b01,
    PFRP_ACCESS = 2'b11
  } pfrp_state_type;
endpackage : pfrp_pkg
`default_nettype wire

// [design/pfrp_top.sv]
// program flash self-read port: address, control and data byte registers
// assumes core writes arrive as one-cycle strobes on the instruction clock
//
// Function
// - setting control bit 0 launches read
// - flash access in second cycle after set
// - first instruction runs, second one suppressed
// - word valid in data bytes next cycle
// - data bytes hold until read or write
// - addresses above implemented space wrap around
`timescale 1ns/100ps
`default_nettype none
module pfrp_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // register writes from the core
  input wire logic addr_low_we,
  input wire logic addr_high_we,
  input wire logic control_we,
  input wire logic data_low_we,
  input wire logic data_high_we,
  input wire logic [7:0] wr_data,
  // flash preload for programming
  input wire logic mem_we,
  input wire logic [9:0] mem_addr,
  input wire logic [13:0] mem_wdata,
  // register contents to the core
  output logic [7:0] prog_addr_low,
  output logic [4:0] prog_addr_high,
  output logic [7:0] prog_mem_control,
  output logic [7:0] prog_data_low,
  output logic [5:0] prog_data_high,
  // pipeline suppression
  output logic suppress_q
);
  logic [13:0] flash_mem [0:pfrp_pkg::DEPTH-1];
  pfrp_pkg::pfrp_state_type state_q;
  logic read_q;
  logic [pfrp_pkg::IMPL_W-1:0] eff_addr;
  logic [pfrp_pkg::ADDR_W-1:0] full_addr;
  logic access;
  logic launch;
  logic [1:0] launch_hist_q;

  // upper address bits ignored, so accesses wrap
  assign full_addr = {prog_addr_high, prog_addr_low};
  assign eff_addr = full_addr[pfrp_pkg::IMPL_W-1:0];
  assign access = (state_q == pfrp_pkg::PFRP_ACCESS);
  assign launch = clk_en && (state_q == pfrp_pkg::PFRP_IDLE) && control_we
    && wr_data[pfrp_pkg::READ_BIT_POS];

  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      flash_mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_addr_low <= pfrp_pkg::ADDR_LOW_RST;
      prog_addr_high <= pfrp_pkg::ADDR_HIGH_RST;
    end else if (clk_en) begin
      if (addr_low_we) begin
        prog_addr_low <= wr_data;
      end
      if (addr_high_we) begin
        prog_addr_high <= wr_data[4:0];
      end
    end
  end

  // sequencer: set cycle, normal instruction, suppressed access slot
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pfrp_pkg::PFRP_IDLE;
      read_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        pfrp_pkg::PFRP_IDLE: begin
          if (control_we && wr_data[pfrp_pkg::READ_BIT_POS]) begin
            read_q <= 1'b1;
            state_q <= pfrp_pkg::PFRP_WAIT;
          end
        end
        pfrp_pkg::PFRP_WAIT: begin
          state_q <= pfrp_pkg::PFRP_ACCESS;
        end
        pfrp_pkg::PFRP_ACCESS: begin
          read_q <= 1'b0;
          state_q <= pfrp_pkg::PFRP_IDLE;
        end
        default: begin
          state_q <= pfrp_pkg::PFRP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    prog_mem_control = 8'h00;
    prog_mem_control[pfrp_pkg::READ_BIT_POS] = read_q;
  end

  // suppress flag marks the slot being discarded
  always_ff @(posedge clk) begin
    if (rst) begin
      suppress_q <= 1'b0;
    end else if (clk_en) begin
      suppress_q <= (state_q == pfrp_pkg::PFRP_WAIT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_data_low <= pfrp_pkg::DATA_LOW_RST;
      prog_data_high <= pfrp_pkg::DATA_HIGH_RST;
    end else if (clk_en) begin
      if (access) begin
        prog_data_low <= flash_mem[eff_addr][7:0];
        prog_data_high <= flash_mem[eff_addr][13:8];
      end else begin
        if (data_low_we) begin
          prog_data_low <= wr_data;
        end
        if (data_high_we) begin
          prog_data_high <= wr_data[5:0];
        end
      end
    end
  end

  // enabled edges since launch, for the access timing check
  always_ff @(posedge clk) begin
    if (rst) begin
      launch_hist_q <= 2'h0;
    end else if (clk_en) begin
      launch_hist_q <= {launch_hist_q[0], launch};
    end
  end

  // checks: launch, refusal and unused control bits
  a_read_launch: assert property (@(posedge clk) disable iff (rst)
    launch |=> read_q)
    else $error("read bit not set");
  a_busy_refused: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_q != pfrp_pkg::PFRP_IDLE)
    |=> state_q != pfrp_pkg::PFRP_WAIT)
    else $error("read relaunched while busy");
  a_control_zero: assert property (@(posedge clk) disable iff (rst)
    prog_mem_control[7:1] == 7'h00)
    else $error("unused control bits set");

  // checks: access slot and clock enable
  a_access_timing: assert property (@(posedge clk) disable iff (rst)
    access == launch_hist_q[1])
    else $error("access not in second cycle");
  a_access_read: assert property (@(posedge clk) disable iff (rst)
    access |-> read_q)
    else $error("access without read bit");
  a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
    (state_q == pfrp_pkg::PFRP_IDLE) |-> !read_q)
    else $error("read bit set while idle");
  a_stall_freeze: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(state_q) && $stable(read_q) && $stable(suppress_q))
    else $error("state moved while disabled");

  // checks: suppressed slot
  a_suppress_slot: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_q == pfrp_pkg::PFRP_WAIT) |=> suppress_q)
    else $error("second slot not suppressed");
  a_first_runs: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_q != pfrp_pkg::PFRP_WAIT) |=> !suppress_q)
    else $error("suppress in wrong slot");
  a_suppress_single: assert property (@(posedge clk) disable iff (rst)
    (clk_en && suppress_q) |=> !suppress_q)
    else $error("suppress longer than one slot");
  a_suppress_read: assert property (@(posedge clk) disable iff (rst)
    suppress_q |-> read_q)
    else $error("suppress without pending read");

  // checks: data bytes
  a_data_load: assert property (@(posedge clk) disable iff (rst)
    (clk_en && access)
    |=> {prog_data_high, prog_data_low} == $past(flash_mem[eff_addr]))
    else $error("data not loaded");
  a_data_hold: assert property (@(posedge clk) disable iff (rst)
    (!clk_en || (!access && !data_low_we && !data_high_we))
    |=> $stable(prog_data_low) && $stable(prog_data_high))
    else $error("data changed without cause");
  a_data_low_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !access && data_low_we) |=> prog_data_low == $past(wr_data))
    else $error("data low not written");
  a_data_high_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !access && data_high_we)
    |=> prog_data_high == $past(wr_data[5:0]))
    else $error("data high not written");

  // checks: address
  a_addr_wrap: assert property (@(posedge clk) disable iff (rst)
    32'(full_addr) % pfrp_pkg::DEPTH == 32'(eff_addr))
    else $error("address not wrapped");
  a_addr_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && addr_low_we) |=> prog_addr_low == $past(wr_data))
    else $error("address low not written");
  a_addr_high_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && addr_high_we) |=> prog_addr_high == $past(wr_data[4:0]))
    else $error("address high not written");
  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    (!clk_en || (!addr_low_we && !addr_high_we))
    |=> $stable(prog_addr_low) && $stable(prog_addr_high))
    else $error("address changed without write");

  // checks: read bit
  a_read_held: assert property (@(posedge clk) disable iff (rst)
    (clk_en && read_q && !access) |=> read_q)
    else $error("read bit dropped early");
  a_read_clear: assert property (@(posedge clk) disable iff (rst)
    (clk_en && access) |=> !read_q)
    else $error("read bit not cleared");

  c_read_done: cover property (@(posedge clk) access ##1 !read_q);
  c_wrapped_read: cover property (@(posedge clk)
    access && prog_addr_high[4:2] != 3'h0);
  c_data_write: cover property (@(posedge clk) clk_en && data_low_we);
  c_stalled_read: cover property (@(posedge clk)
    !clk_en && state_q == pfrp_pkg::PFRP_WAIT);
endmodule : pfrp_top
`default_nettype wire

// [tb/pfrp_core_model.sv]
// core pipeline model issuing register writes
// assumes the port samples on rising clk
`timescale 1ns/100ps
`default_nettype none
module pfrp_core_model (
  // clock
  input wire logic clk,
  // write strobes and data
  output logic [4:0] we,
  output logic [7:0] wr_data
);
  initial begin
    we = 5'h00;
    wr_data = 8'h00;
  end
  task automatic put(input int sel, input logic [7:0] v);
    @(negedge clk);
    we = 5'h01 << sel;
    wr_data = v;
    @(negedge clk);
    we = 5'h00;
    wr_data = ~v;
  endtask : put
  // idle slots after the request act as fillers
  task automatic read(input logic [12:0] a);
    put(1, {3'h0, a[12:8]});
    put(0, a[7:0]);
    put(2, 8'h01);
  endtask : read
endmodule : pfrp_core_model
`default_nettype wire

// [tb/pfrp_top_test.sv]
// testbench for the program flash read port
// assumes the core model drives the write strobes
`timescale 1ns/100ps
`default_nettype none
module pfrp_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic mem_we = 1'b0;
  logic [9:0] mem_addr = 10'h000;
  logic [13:0] mem_wdata = 14'h0000;
  logic [4:0] we, addr_high;
  logic [7:0] wr_data, addr_low, control, data_low;
  logic [5:0] data_high;
  logic suppress;
  int errors = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  pfrp_core_model i_pfrp_core_model (.clk(clk), .we(we), .wr_data(wr_data));
  pfrp_top i_pfrp_top (.clk(clk), .rst(rst), .clk_en(clk_en),
    .addr_low_we(we[0]), .addr_high_we(we[1]), .control_we(we[2]),
    .data_low_we(we[3]), .data_high_we(we[4]), .wr_data(wr_data),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .prog_addr_low(addr_low), .prog_addr_high(addr_high),
    .prog_mem_control(control), .prog_data_low(data_low),
    .prog_data_high(data_high), .suppress_q(suppress));
  task automatic check(input string what, input logic [13:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic load(input logic [9:0] a, input logic [13:0] w);
    @(negedge clk);
    mem_we = 1'b1;
    mem_addr = a;
    mem_wdata = w;
    @(negedge clk);
    mem_we = 1'b0;
  endtask : load
  task automatic s_read(input logic [12:0] a, input logic [13:0] w);
    i_pfrp_core_model.read(a);
    check("read bit", {13'h0000, control[0]}, 14'h0001);
    check("address", {1'b0, addr_high, addr_low}, {1'b0, a});
    check("suppress early", {13'h0000, suppress}, 14'h0000);
    @(negedge clk);
    check("suppress", {13'h0000, suppress}, 14'h0001);
    @(negedge clk);
    check("suppress end", {13'h0000, suppress}, 14'h0000);
    check("read bit clear", {6'h00, control}, 14'h0000);
    check("word", {data_high, data_low}, w);
  endtask : s_read
  task automatic s_hold(input logic [13:0] w);
    repeat (4) @(negedge clk);
    check("word held", {data_high, data_low}, w);
    i_pfrp_core_model.put(3, 8'hC3);
    check("data write", {6'h00, data_low}, 14'h00C3);
    i_pfrp_core_model.put(4, 8'h15);
    check("data high write", {data_high, data_low}, 14'h15C3);
  endtask : s_hold
  task automatic s_reset;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check("reset address", {1'b0, addr_high, addr_low}, 14'h0000);
    check("reset control", {6'h00, control}, 14'h0000);
    check("reset word", {data_high, data_low}, 14'h0000);
    check("reset suppress", {13'h0000, suppress}, 14'h0000);
  endtask : s_reset
  task automatic s_stall(input logic [12:0] a, input logic [13:0] w);
    i_pfrp_core_model.read(a);
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    check("stalled read bit", {13'h0000, control[0]}, 14'h0001);
    check("stalled suppress", {13'h0000, suppress}, 14'h0000);
    check("stalled word", {data_high, data_low}, 14'h0000);
    clk_en = 1'b1;
    @(negedge clk);
    check("suppress after stall", {13'h0000, suppress}, 14'h0001);
    @(negedge clk);
    check("read bit after stall", {6'h00, control}, 14'h0000);
    check("word after stall", {data_high, data_low}, w);
  endtask : s_stall
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    load(10'h0A5, 14'h2B3C);
    load(10'h3FF, 14'h15A7);
    s_read(13'h00A5, 14'h2B3C);
    s_read(13'h03FF, 14'h15A7);
    s_read(13'h1CA5, 14'h2B3C);
    s_hold(14'h2B3C);
    s_reset();
    s_stall(13'h03FF, 14'h15A7);
    give_verdict();
  end
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule : pfrp_top_test
`default_nettype wire
